// File: verilog/qco_pkg.sv
// Shared constants and bus carrier types for the quadrature and commutation output stage
package qco_pkg;
   localparam int ADDR_W        = 8;
   localparam int DATA_W        = 32;
   localparam int ANGLE_W       = 16;
   localparam int TIMER_W       = 10;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_STATUS  = 6'h0E;
   localparam logic [5:0] IDX_ANGLE   = 6'h16;
   localparam logic [5:0] IDX_OUTCFG  = 6'h25;
   localparam logic [5:0] IDX_HYSTCFG = 6'h3E;
   // Output configuration fields
   localparam int SLEW_LSB      = 6;
   localparam int SLEW_MSB      = 11;
   localparam int RES_LSB       = 2;
   localparam int RES_MSB       = 5;
   localparam logic [31:0] OUTCFG_MASK  = 32'h0000_0FFC;
   localparam logic [31:0] OUTCFG_RESET = 32'h0000_0000;
   // Hysteresis configuration fields
   localparam int HYST_LSB      = 23;
   localparam int HYST_MSB      = 25;
   localparam int HYST_EN_BIT   = 26;
   localparam int CHAN_SEL_BIT  = 27;
   localparam logic [31:0] HYSTCFG_MASK  = 32'h0F80_0000;
   localparam logic [31:0] HYSTCFG_RESET = 32'h0000_0000;
   // Status fields
   localparam int STAT_HEAD_BIT = 1;
   localparam int STAT_SLEW_BIT = 4;
   // Resolution shift limits (14-bit to 2-bit quadrature position counts)
   localparam logic [3:0] RES_MIN = 4'h2;
   localparam logic [3:0] RES_MAX = 4'hE;
   // Slew timing: one slew unit per code step plus one
   localparam int SLEW_UNIT_NS   = 125;
   localparam int CLK_PERIOD_NS  = 20;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int SAMPLE_CYC     = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Commutation sector boundaries on the 16-bit electrical angle
   localparam logic [15:0] SECT_1 = 16'h2AAB;
   localparam logic [15:0] SECT_2 = 16'h5555;
   localparam logic [15:0] SECT_3 = 16'h8000;
   localparam logic [15:0] SECT_4 = 16'hAAAB;
   localparam logic [15:0] SECT_5 = 16'hD555;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic              rready;
   } qco_axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } qco_axi_rsp_t;
endpackage

// File: verilog/qco_comm.sv
// Brushless motor commutation decoder (U, V, W) from the filtered angle
module qco_comm (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [15:0] angle_i,
   input  wire logic [3:0]  pole_code_i,
   output logic             comm_u_o,
   output logic             comm_v_o,
   output logic             comm_w_o
);
   import qco_pkg::*;

   typedef struct packed {
      logic u;
      logic v;
      logic w;
   } qco_comm_state_t;

   qco_comm_state_t st;
   qco_comm_state_t next_st;
   logic [20:0]     prod;
   logic [15:0]     elec;
   logic [2:0]      sector;

   always_comb begin
      prod = angle_i * {1'b0, pole_code_i} + {5'h00, angle_i};
      elec = prod[15:0];
      if (elec < SECT_1) begin
         sector = 3'h0;
      end else if (elec < SECT_2) begin
         sector = 3'h1;
      end else if (elec < SECT_3) begin
         sector = 3'h2;
      end else if (elec < SECT_4) begin
         sector = 3'h3;
      end else if (elec < SECT_5) begin
         sector = 3'h4;
      end else begin
         sector = 3'h5;
      end
      next_st.u = (sector <= 3'h2);
      next_st.v = (sector >= 3'h2) && (sector <= 3'h4);
      next_st.w = (sector >= 3'h4) || (sector == 3'h0);
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign comm_u_o = st.u;
   assign comm_v_o = st.v;
   assign comm_w_o = st.w;

   a_comm_valid_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $past(rst_n_i) |-> !((st.u == st.v) && (st.v == st.w)))
      else $error("Commutation outputs show an illegal all-equal code");
endmodule

// File: verilog/qco_top.sv
// Quadrature and commutation output stage with hysteresis, slew limiting and AXI4-Lite registers
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module qco_top (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire qco_pkg::qco_axi_req_t axi_i,
   output qco_pkg::qco_axi_rsp_t     axi_o,
   input  wire logic [15:0]          angle_p_i,
   input  wire logic [15:0]          angle_s_i,
   input  wire logic                 sample_i,
   output logic                      quad_a_o,
   output logic                      quad_b_o,
   output logic                      comm_u_o,
   output logic                      comm_v_o,
   output logic                      comm_w_o,
   output logic                      slew_limit_flag_o,
   output logic                      window_head_direction_o
);
   import qco_pkg::*;

   typedef struct packed {
      logic                aw_got;
      logic [ADDR_W-1:0]   aw_addr;
      logic                w_got;
      logic [DATA_W-1:0]   w_data;
      logic [3:0]          w_strb;
      logic                bvalid;
      logic [1:0]          bresp;
      logic                rvalid;
      logic [DATA_W-1:0]   rdata;
      logic [1:0]          rresp;
      logic [31:0]         outcfg;
      logic [31:0]         hystcfg;
      logic [15:0]         comp;
      logic                head;
      logic [15:0]         pos;
      logic [TIMER_W-1:0]  timer;
      logic                flag;
      logic                qa;
      logic                qb;
   } qco_state_t;

   qco_state_t         st;
   qco_state_t         next_st;
   logic [5:0]         quad_slew_code;
   logic [3:0]         quad_commutation_resolution;
   logic [3:0]         shift;
   logic [2:0]         angle_window_width_field;
   logic [15:0]        angle_window_width;
   logic               slew_en;
   logic               hyst_en;
   logic [15:0]        chan_angle;
   logic signed [15:0] delta;
   logic [15:0]        target;
   logic [15:0]        mask;
   logic [15:0]        step16;
   logic [15:0]        d16;
   logic               nonzero;
   logic               multi;
   logic [TIMER_W-1:0] hold_cyc;
   int                 hold_int;
   logic [DATA_W-1:0]  wmerged;
   logic [DATA_W-1:0]  rword;
   logic               rhit;

   always_comb begin
      quad_slew_code = st.outcfg[SLEW_MSB:SLEW_LSB];
      quad_commutation_resolution = st.outcfg[RES_MSB:RES_LSB];
      slew_en = (quad_slew_code != 6'h00);
      if (quad_commutation_resolution < RES_MIN) begin
         shift = RES_MIN;
      end else if (quad_commutation_resolution > RES_MAX) begin
         shift = RES_MAX;
      end else begin
         shift = quad_commutation_resolution;
      end
      angle_window_width_field = st.hystcfg[HYST_MSB:HYST_LSB];
      angle_window_width = 16'h0001 << ({1'b0, angle_window_width_field} + 4'h1);
      hyst_en = st.hystcfg[HYST_EN_BIT];
      chan_angle = st.hystcfg[CHAN_SEL_BIT] ? angle_s_i : angle_p_i;
      delta = $signed(chan_angle - st.comp);
      hold_int = (SLEW_UNIT_NS * (int'(quad_slew_code) + 1) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      hold_cyc = TIMER_W'(hold_int);
      mask = 16'hFFFF >> shift;
      target = st.comp >> shift;
      step16 = 16'h0001 << shift;
      d16 = (target - st.pos) << shift;
      nonzero = (d16 != 16'h0000);
      multi = nonzero && (d16 != step16) && (d16 != (16'h0000 - step16));
   end

   // Byte-lane merge and read decode
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmerged[i*8 +: 8] = 8'h00;
      end
      for (int i = 0; i < 4; i++) begin
         if (st.aw_addr[7:2] == IDX_OUTCFG) begin
            wmerged[i*8 +: 8] = st.w_strb[i] ? st.w_data[i*8 +: 8] : st.outcfg[i*8 +: 8];
         end else begin
            wmerged[i*8 +: 8] = st.w_strb[i] ? st.w_data[i*8 +: 8] : st.hystcfg[i*8 +: 8];
         end
      end
      rhit = 1'b1;
      rword = 32'h0000_0000;
      case (axi_i.araddr[7:2])
         IDX_STATUS: begin
            rword[STAT_HEAD_BIT] = st.head;
            rword[STAT_SLEW_BIT] = st.flag;
         end
         IDX_ANGLE: begin
            rword[15:0] = st.comp;
         end
         IDX_OUTCFG: begin
            rword = st.outcfg & OUTCFG_MASK;
         end
         IDX_HYSTCFG: begin
            rword = st.hystcfg & HYSTCFG_MASK;
         end
         default: begin
            rhit = 1'b0;
         end
      endcase
   end

   always_comb begin
      next_st = st;
      // Write channel: address and data taken in either order
      if (axi_i.awvalid && axi_o.awready) begin
         next_st.aw_got = 1'b1;
         next_st.aw_addr = axi_i.awaddr;
      end
      if (axi_i.wvalid && axi_o.wready) begin
         next_st.w_got = 1'b1;
         next_st.w_data = axi_i.wdata;
         next_st.w_strb = axi_i.wstrb;
      end
      if (st.aw_got && st.w_got && !st.bvalid) begin
         next_st.aw_got = 1'b0;
         next_st.w_got = 1'b0;
         next_st.bvalid = 1'b1;
         next_st.bresp = RESP_OKAY;
         case (st.aw_addr[7:2])
            IDX_OUTCFG: begin
               next_st.outcfg = wmerged & OUTCFG_MASK;
            end
            IDX_HYSTCFG: begin
               next_st.hystcfg = wmerged & HYSTCFG_MASK;
            end
            IDX_STATUS, IDX_ANGLE: begin
               next_st.bresp = RESP_OKAY;
            end
            default: begin
               next_st.bresp = RESP_SLVERR;
            end
         endcase
      end
      if (st.bvalid && axi_i.bready) begin
         next_st.bvalid = 1'b0;
      end
      // Read channel
      if (st.rvalid && axi_i.rready) begin
         next_st.rvalid = 1'b0;
      end
      if (axi_i.arvalid && axi_o.arready) begin
         next_st.rvalid = 1'b1;
         next_st.rdata = rword;
         next_st.rresp = rhit ? RESP_OKAY : RESP_SLVERR;
      end

      // Angle hysteresis, updated once per sample
      if (sample_i) begin
         if (!hyst_en) begin
            next_st.comp = chan_angle;
            if (delta > 16'sh0000) begin
               next_st.head = 1'b1;
            end else if (delta < 16'sh0000) begin
               next_st.head = 1'b0;
            end
         end else if (st.head) begin
            if (delta > 16'sh0000) begin
               next_st.comp = chan_angle;
            end else if (delta < -$signed(angle_window_width)) begin
               next_st.comp = chan_angle;
               next_st.head = 1'b0;
            end
         end else begin
            if (delta < 16'sh0000) begin
               next_st.comp = chan_angle;
            end else if (delta > $signed(angle_window_width)) begin
               next_st.comp = chan_angle;
               next_st.head = 1'b1;
            end
         end
      end

      // Quadrature position with optional slew limiting
      if (!slew_en) begin
         next_st.pos = target;
         next_st.timer = '0;
      end else if ((st.timer == '0) && nonzero) begin
         // One Gray step toward the target, then hold; back-fills after reversal
         next_st.pos = d16[15] ? ((st.pos - 16'h0001) & mask) : ((st.pos + 16'h0001) & mask);
         next_st.timer = hold_cyc - TIMER_W'(1);
      end else if (st.timer != '0) begin
         next_st.timer = st.timer - TIMER_W'(1);
      end
      next_st.flag = slew_en && nonzero && ((st.timer != '0) || multi);
      next_st.qa = next_st.pos[1] ^ next_st.pos[0];
      next_st.qb = next_st.pos[1];
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st <= '0;
         st.outcfg <= OUTCFG_RESET;
         st.hystcfg <= HYSTCFG_RESET;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      axi_o.awready = !st.aw_got && !st.bvalid;
      axi_o.wready  = !st.w_got && !st.bvalid;
      axi_o.bvalid  = st.bvalid;
      axi_o.bresp   = st.bresp;
      axi_o.arready = !st.rvalid;
      axi_o.rvalid  = st.rvalid;
      axi_o.rdata   = st.rdata;
      axi_o.rresp   = st.rresp;
   end

   assign quad_a_o = st.qa;
   assign quad_b_o = st.qb;
   assign slew_limit_flag_o = st.flag;
   assign window_head_direction_o = st.head;

   qco_comm u_comm (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .angle_i     (st.comp),
      .pole_code_i (quad_commutation_resolution),
      .comm_u_o    (comm_u_o),
      .comm_v_o    (comm_v_o),
      .comm_w_o    (comm_w_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   a_slew_off_jump: assert property (
      !slew_en |=> (st.pos == $past(target)))
      else $error("Output did not jump to target with slew off");

   a_hold_min_time: assert property (
      (slew_en && $past(slew_en) && $changed(st.pos)) |-> ($past(st.timer) == '0))
      else $error("Quadrature state changed before slew time ended");

   a_single_gray_step: assert property (
      (slew_en && $past(slew_en) && $changed(st.pos) && ($past(shift) == shift))
      |-> ((((st.pos - $past(st.pos)) & mask) == 16'h0001) || (((st.pos - $past(st.pos)) & mask) == mask)))
      else $error("Slew-limited output skipped a quadrature state");

   a_slew_flag_set: assert property (
      (slew_en && nonzero && (st.timer != '0)) |=> st.flag)
      else $error("Slew flag missing while limiting");

   a_flag_needs_slew: assert property (
      st.flag |-> $past(slew_en))
      else $error("Slew flag high with limiting disabled");

   a_gray_output: assert property (
      $changed({st.qa, st.qb}) && slew_en && $past(slew_en) |-> $onehot({st.qa, st.qb} ^ $past({st.qa, st.qb})))
      else $error("A and B changed together");

   a_track_no_lag: assert property (
      (sample_i && (!hyst_en || (st.head && (delta > 16'sh0000)))) |=> (st.comp == $past(chan_angle)))
      else $error("Filtered angle lags the channel angle");

   a_head_flip_cause: assert property (
      $changed(st.head) |-> $past(sample_i))
      else $error("Head direction changed without a sample");

   a_freeze_in_window: assert property (
      (sample_i && hyst_en && st.head && (delta <= 16'sh0000) && (delta >= -$signed(angle_window_width)))
      |=> $stable(st.comp) ##0 st.head)
      else $error("Filtered angle moved inside the window");

   a_timer_reload: assert property (
      (slew_en && $past(slew_en) && $changed(st.pos) && $stable(quad_slew_code))
      |-> (st.timer == $past(hold_cyc) - TIMER_W'(1)))
      else $error("Slew hold time not reloaded correctly");

   a_bresp_stands: assert property (
      (st.bvalid && !axi_i.bready) |=> st.bvalid)
      else $error("Write response dropped before it was taken");
endmodule

// File: verification/qco_rx_model.sv
// Quadrature receiver model: counts A/B steps and measures edge spacing
module qco_rx_model (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic clr_i,
   input  wire logic a_i,
   input  wire logic b_i,
   output int        count_o,
   output int        bad_o,
   output int        min_gap_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] last;
   logic [1:0] now;
   logic [1:0] step;
   int         gap;
   bit         seen;
   assign now = {b_i, a_i ^ b_i};
   assign step = now - last;
   always @(posedge clk_i) begin
      if (!rst_n_i || clr_i) begin
         count_o <= 0;
         bad_o <= 0;
         min_gap_o <= 100000;
         gap <= 0;
         seen <= 1'b0;
         last <= now;
      end else begin
         gap <= gap + 1;
         if (now != last) begin
            last <= now;
            gap <= 1;
            seen <= 1'b1;
            // First edge after a clear has no reference spacing
            if (seen && gap < min_gap_o) begin
               min_gap_o <= gap;
            end
            // Two-bit change is a skipped state
            case (step)
               2'd1: count_o <= count_o + 1;
               2'd3: count_o <= count_o - 1;
               default: bad_o <= bad_o + 1;
            endcase
         end
      end
   end
endmodule

// File: verification/quadrature_commutation_output_bench.sv
// Self-checking bench for the quadrature and commutation output stage
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin failures++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, got, exp); end end
module quadrature_commutation_output_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import qco_pkg::*;
   logic         clk_i = 1'b0;
   logic         rst_n_i = 1'b0;
   qco_axi_req_t req = '0;
   qco_axi_rsp_t rsp;
   logic [15:0]  ang_p = '0;
   logic [15:0]  ang_s = '0;
   logic         sample = 1'b0;
   logic         clr = 1'b0;
   logic         qa, qb, cu, cv, cw, flag, head;
   int           count, bad, min_gap;
   int           failures = 0;
   int           num_checks = 0;
   logic [31:0]  rd;
   logic [1:0]   resp;
   logic [15:0]  h_in [5] = '{16'd1010, 16'd1005, 16'd1002, 16'd1001, 16'd1003};
   logic [15:0]  h_out [5] = '{16'd1010, 16'd1010, 16'd1010, 16'd1001, 16'd1001};
   logic         h_dir [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

   always #10 clk_i = ~clk_i;

   qco_top u_dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .axi_i(req), .axi_o(rsp), .angle_p_i(ang_p), .angle_s_i(ang_s),
      .sample_i(sample), .quad_a_o(qa), .quad_b_o(qb), .comm_u_o(cu), .comm_v_o(cv), .comm_w_o(cw),
      .slew_limit_flag_o(flag), .window_head_direction_o(head));
   qco_rx_model u_rx (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .clr_i(clr), .a_i(qa), .b_i(qb),
      .count_o(count), .bad_o(bad), .min_gap_o(min_gap));

   task automatic end_sim();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [5:0] idx, input logic [31:0] d);
      bit aw_t, w_t, b_t;
      @(posedge clk_i);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      do begin
         @(negedge clk_i);
         aw_t = req.awvalid && rsp.awready;
         w_t = req.wvalid && rsp.wready;
         b_t = rsp.bvalid === 1'b1;
         resp = rsp.bresp;
         @(posedge clk_i);
         if (aw_t) req.awvalid <= 1'b0;
         if (w_t) req.wvalid <= 1'b0;
      end while (!b_t);
      req.bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [5:0] idx);
      bit ar_t, r_t;
      @(posedge clk_i);
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      req.rready <= 1'b1;
      do begin
         @(negedge clk_i);
         ar_t = req.arvalid && rsp.arready;
         r_t = rsp.rvalid === 1'b1;
         rd = rsp.rdata;
         resp = rsp.rresp;
         @(posedge clk_i);
         if (ar_t) req.arvalid <= 1'b0;
      end while (!r_t);
      req.rready <= 1'b0;
   endtask

   task automatic samp(input logic [15:0] p, input logic [15:0] s);
      @(posedge clk_i);
      ang_p <= p;
      ang_s <= s;
      sample <= 1'b1;
      @(posedge clk_i);
      sample <= 1'b0;
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic clr_rx();
      @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
   endtask

   // Jump by n quadrature steps with a given slew code, resolution code 2
   task automatic slew_run(input int code, input logic [15:0] ang, input int n);
      int h, an;
      h = (SLEW_UNIT_NS * (code + 1) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      an = n < 0 ? -n : n;
      wr(IDX_OUTCFG, 32'(code) << SLEW_LSB | 32'h8);
      clr_rx();
      samp(ang, 16'h0);
      `CHECK(flag, 1'b1)
      `CHECK(count, (n < 0 ? -1 : 1))
      repeat ((an + 2) * h) @(posedge clk_i);
      @(negedge clk_i);
      `CHECK(count, n)
      `CHECK(bad, 0)
      `CHECK(min_gap, h)
      `CHECK(flag, 1'b0)
   endtask

   function automatic logic [2:0] uvw(input logic [15:0] e);
      int s;
      s = e < SECT_1 ? 0 : e < SECT_2 ? 1 : e < SECT_3 ? 2 : e < SECT_4 ? 3 : e < SECT_5 ? 4 : 5;
      return {s <= 2, s >= 2 && s <= 4, s >= 4 || s == 0};
   endfunction

   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      end_sim();
   end

   initial begin
      logic [15:0] a;
      repeat (16) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      `CHECK({qa, qb}, 2'b00)
      rd_reg(IDX_OUTCFG);
      `CHECK(rd, OUTCFG_RESET)
      rd_reg(IDX_HYSTCFG);
      `CHECK(rd, HYSTCFG_RESET)
      wr(IDX_STATUS, 32'hFFFF_FFFF);
      `CHECK(resp, RESP_OKAY)
      rd_reg(IDX_STATUS);
      `CHECK(rd, 32'h0)
      wr(IDX_OUTCFG, 32'hFFFF_FFFF);
      rd_reg(IDX_OUTCFG);
      `CHECK(rd, OUTCFG_MASK)
      wr(IDX_HYSTCFG, 32'hFFFF_FFFF);
      rd_reg(IDX_HYSTCFG);
      `CHECK(rd, HYSTCFG_MASK)
      wr(6'h01, 32'h1);
      `CHECK(resp, RESP_SLVERR)
      rd_reg(6'h01);
      `CHECK(rd, 32'h0)
      `CHECK(resp, RESP_SLVERR)
      wr(IDX_HYSTCFG, 32'h0);
      wr(IDX_OUTCFG, 32'h8);
      clr_rx();
      for (int i = 1; i < 5; i++) begin
         samp(16'(4 * i), 16'h0);
         `CHECK({qa, qb}, {i[0] ^ i[1], i[1]})
      end
      `CHECK(count, 4)
      samp(16'd40, 16'h0);
      `CHECK({qa, qb}, 2'b11)
      `CHECK(flag, 1'b0)
      slew_run(1, 16'd72, 8);
      slew_run(7, 16'd60, -3);
      for (int c = 0; c < 16; c++) begin
         a = 16'h1234 + 16'(c * 16'h0777);
         wr(IDX_OUTCFG, 32'(c) << RES_LSB);
         samp(a, 16'h0);
         `CHECK({cu, cv, cw}, uvw(16'(a * (c + 1))))
      end
      wr(IDX_OUTCFG, 32'h0);
      wr(IDX_HYSTCFG, 32'h1 << CHAN_SEL_BIT);
      samp(16'h0100, 16'h4000);
      `CHECK({cu, cv, cw}, 3'b100)
      rd_reg(IDX_ANGLE);
      `CHECK(rd[15:0], 16'h4000)
      wr(IDX_HYSTCFG, 32'h0);
      samp(16'd990, 16'h0);
      samp(16'd1000, 16'h0);
      `CHECK(head, 1'b1)
      wr(IDX_OUTCFG, 32'h1 << SLEW_LSB | 32'h8);
      wr(IDX_HYSTCFG, 32'h1 << HYST_EN_BIT | 32'h2 << HYST_LSB);
      clr_rx();
      for (int i = 0; i < 5; i++) begin
         samp(h_in[i], 16'h0);
         rd_reg(IDX_ANGLE);
         `CHECK(rd[15:0], h_out[i])
         rd_reg(IDX_STATUS);
         `CHECK(rd[STAT_HEAD_BIT], h_dir[i])
         `CHECK(head, h_dir[i])
      end
      // Two steps up, then two back-filled steps after the reversal
      repeat (60) @(posedge clk_i);
      @(negedge clk_i);
      `CHECK(count, 0)
      `CHECK(bad, 0)
      `CHECK(min_gap, (SLEW_UNIT_NS * 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS)
      end_sim();
   end
endmodule
